// ===== rtl/uef_pkg.sv
// Function
// - Stall flag sets on STALL received (host) or transmitted (device).
// - Attach flag sets when a peripheral attach is detected.
// - Attach valid only with host enabled, bus idle 2.5 us, not SE0.
// - Resume flag sets after K state held 2.5 us on a data line.
// - Idle flag sets after 3 ms continuous idle bus state.
// - Clearing token-done flag advances the token status FIFO.
// - Frame-start flag sets on SOF token (device) or threshold (host).
// - Error summary sets only from enabled error conditions.
// - Device mode: bit 0 is bus reset flag, set on valid reset.
// - Host mode: bit 0 is detach flag, set on peripheral detach.
// - Hardware sets flags; writing one clears, zero leaves unchanged.
// - Ping-pong reset returns all even/odd pointers to even bank.
// - Device mode: module enable switches module on and off.
// - Host mode: SOF enable sends an SOF token every 1 ms.
// - All host control logic resets whenever host enable toggles.
// - Host mode: clearing resume appends a low-speed end of packet.
package uef_pkg;
  localparam int unsigned CLK_HZ         = 40000000;
  localparam int unsigned SETTLE_NS      = 2500;
  localparam int unsigned IDLE_US        = 3000;
  localparam int unsigned FRAME_US       = 1000;
  localparam int unsigned LS_EOP_NS      = 1330;
  localparam int unsigned SETTLE_CYC     = (SETTLE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned IDLE_CYC       = IDLE_US * (CLK_HZ / 1000000);
  localparam int unsigned FRAME_CYC      = FRAME_US * (CLK_HZ / 1000000);
  localparam int unsigned EOP_CYC        = (LS_EOP_NS * (CLK_HZ / 1000000) + 999) / 1000;
  // Register byte offsets
  localparam logic [7:0]  OFS_FLAGS      = 8'h00;
  localparam logic [7:0]  OFS_FLAG_EN    = 8'h04;
  localparam logic [7:0]  OFS_ERR_EN     = 8'h08;
  localparam logic [7:0]  OFS_CTRL       = 8'h0c;
  localparam logic [7:0]  OFS_STAT       = 8'h10;
  // Flag bit positions
  localparam int unsigned B_STALL        = 7;
  localparam int unsigned B_ATTACH       = 6;
  localparam int unsigned B_RESUME       = 5;
  localparam int unsigned B_IDLE         = 4;
  localparam int unsigned B_TOKEN        = 3;
  localparam int unsigned B_SOF          = 2;
  localparam int unsigned B_ERR          = 1;
  localparam int unsigned B_RST          = 0;
  // Control bit positions
  localparam int unsigned C_ENABLE       = 0;
  localparam int unsigned C_PPRST        = 1;
  localparam int unsigned C_RESUME       = 2;
  localparam int unsigned C_HOST_OPERATION_ENABLE       = 3;
  localparam int unsigned C_FRAME_START_ENABLE        = 4;
  localparam logic [7:0]  FLAGS_RST      = 8'h00;
  localparam logic [7:0]  CTRL_RST       = 8'h00;
  // Line states from the transceiver
  typedef enum logic [1:0] {
    LS_SE0 = 2'b00,
    LS_J   = 2'b01,
    LS_K   = 2'b10,
    LS_SE1 = 2'b11
  } uef_line_t;
endpackage

// ===== rtl/uef_tok_if.sv
`timescale 1ns/1ps
`default_nettype none
// Token status FIFO handshake between the top and its memory
interface uef_tok_if;
  logic       push;
  logic [7:0] wdata;
  logic       pop;
  logic       flush;
  logic       empty;
  logic [7:0] rdata;
  modport ctl (output push, output wdata, output pop, output flush,
               input empty, input rdata);
  modport mem (input push, input wdata, input pop, input flush,
               output empty, output rdata);
endinterface
`default_nettype wire

// ===== rtl/uef_tok_fifo.sv
`timescale 1ns/1ps
`default_nettype none
// Small token status memory, read data registered
module uef_tok_fifo #(
  parameter int unsigned DEPTH = 4
) (
  input  wire logic i_ref_clk,
  input  wire logic i_srst,
  uef_tok_if.mem    tok
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [7:0]  mem [DEPTH];
  logic [AW:0] wp;
  logic [AW:0] rp;
  logic [AW:0] next_wp;
  logic [AW:0] next_rp;
  logic [7:0]  rdata_q;
  logic [7:0]  next_rdata;
  logic        full;

  // Pointer arithmetic; a push into a full memory is dropped
  always_comb begin
    full       = (wp[AW-1:0] == rp[AW-1:0]) && (wp[AW] != rp[AW]);
    next_wp    = wp;
    next_rp    = rp;
    if (tok.push && !full) begin
      next_wp = wp + 1'b1;
    end
    if (tok.pop && (wp != rp)) begin
      next_rp = rp + 1'b1;
    end
    if (tok.flush) begin
      next_wp = '0;
      next_rp = '0;
    end
    next_rdata = mem[next_rp[AW-1:0]];
    if (tok.push && !full && (next_rp == wp)) begin
      next_rdata = tok.wdata;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      wp      <= '0;
      rp      <= '0;
      rdata_q <= 8'h00;
    end else begin
      wp      <= next_wp;
      rp      <= next_rp;
      rdata_q <= next_rdata;
    end
    if (tok.push && !full) begin
      mem[wp[AW-1:0]] <= tok.wdata;
    end
  end

  assign tok.empty = (wp == rp);
  assign tok.rdata = rdata_q;
endmodule
`default_nettype wire

// ===== rtl/uef_top.sv
`timescale 1ns/1ps
`default_nettype none
module uef_top #(
  parameter int unsigned IDLE_CYCLES  = uef_pkg::IDLE_CYC,
  parameter int unsigned FRAME_CYCLES = uef_pkg::FRAME_CYC,
  parameter int unsigned TOK_DEPTH    = 4
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_srst,
  // AHB-Lite slave
  input  wire logic        i_hsel,
  input  wire logic [7:0]  i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // Line state pins (D+ , D-) from the transceiver
  input  wire logic        i_dp,
  input  wire logic        i_dm,
  // Event strobes from the protocol engine
  input  wire logic        i_stall_evt,
  input  wire logic        i_token_done,
  input  wire logic [7:0]  i_token_stat,
  input  wire logic        i_sof_rx,
  input  wire logic [7:0]  i_err_evt,
  input  wire logic        i_attach_evt,
  input  wire logic        i_detach_evt,
  input  wire logic        i_bus_reset_evt,
  input  wire logic        i_token_busy,
  // Controls to the engine
  output logic             o_module_on,
  output logic             o_pingpong_even,
  output logic             o_host_logic_rst,
  output logic             o_sof_send,
  output logic             o_resume_drive,
  output logic             o_ls_eop_drive,
  output logic             o_irq
);
  import uef_pkg::*;

  typedef enum logic [1:0] {
    RS_OFF  = 2'b00,
    RS_K    = 2'b01,
    RS_EOP  = 2'b10
  } uef_rsm_t;

  logic [2:0]  dp_s, dm_s;
  logic [1:0]  line;
  logic        ap_valid, ap_write;
  logic [7:0]  ap_addr;
  logic [7:0]  flags, next_flags;
  logic [7:0]  flag_en, next_flag_en;
  logic [7:0]  err_en, next_err_en;
  logic [7:0]  ctrl, next_ctrl;
  logic [31:0] rdata, next_rdata;
  logic [12:0] settle_cnt, next_settle_cnt;
  logic [12:0] k_cnt, next_k_cnt;
  logic [17:0] idle_cnt, next_idle_cnt;
  logic [17:0] frame_cnt, next_frame_cnt;
  logic [7:0]  eop_cnt, next_eop_cnt;
  logic        host_q, next_host_q;
  logic        attach_ok;
  logic        sof_tick;
  uef_rsm_t    rs, next_rs;
  logic [7:0]  wr_ones;
  uef_tok_if   tok ();

  // Saturating counter step used by all line timers
  // Saturates at top so a narrow timer never wraps and fires again
  function automatic logic [17:0] sat_inc(input logic [17:0] v, input logic run,
                                          input logic [17:0] top);
    sat_inc = !run ? 18'h00000 : ((v >= top) ? top : v + 18'h00001);
  endfunction

  uef_tok_fifo #(.DEPTH(TOK_DEPTH)) u_tok (
    .i_ref_clk (i_ref_clk),
    .i_srst    (i_srst),
    .tok       (tok)
  );

  // Pin synchronisers; a change counts once stages two and three agree
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      dp_s <= 3'h0;
      dm_s <= 3'h0;
      line <= LS_SE0;
    end else begin
      dp_s <= {dp_s[1:0], i_dp};
      dm_s <= {dm_s[1:0], i_dm};
      if ((dp_s[1] == dp_s[2]) && (dm_s[1] == dm_s[2])) begin
        line <= {dm_s[2], dp_s[2]};
      end
    end
  end

  // AHB-Lite: zero wait states, always OKAY
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr  <= 8'h00;
    end else if (i_hready) begin
      ap_valid <= i_hsel && i_htrans[1];
      ap_write <= i_hwrite;
      ap_addr  <= i_haddr;
    end
  end
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;
  assign o_hrdata    = rdata;

  // Flag clear mask: ones written into the flag register
  assign wr_ones   = (ap_valid && ap_write && ap_addr == OFS_FLAGS) ? i_hwdata[7:0] : 8'h00;
  assign attach_ok = ctrl[C_HOST_OPERATION_ENABLE] && (settle_cnt >= 13'(SETTLE_CYC)) && (line != LS_SE0);
  assign sof_tick  = ctrl[C_HOST_OPERATION_ENABLE] && ctrl[C_FRAME_START_ENABLE] && (frame_cnt == 18'(FRAME_CYCLES - 1));

  // Register, flag and timer next state
  always_comb begin
    next_flags   = flags & ~wr_ones;
    next_flag_en = flag_en;
    next_err_en  = err_en;
    next_ctrl    = ctrl;
    next_rdata   = 32'h00000000;
    if (ap_valid && ap_write) begin
      if (ap_addr == OFS_FLAG_EN) begin
        next_flag_en = i_hwdata[7:0];
      end else if (ap_addr == OFS_ERR_EN) begin
        next_err_en = i_hwdata[7:0];
      end else if (ap_addr == OFS_CTRL) begin
        next_ctrl = i_hwdata[7:0];
      end
    end
    // Set wins over a clear in the same cycle, except for the token flag
    if (i_stall_evt) next_flags[B_STALL] = 1'b1;
    if (i_attach_evt && attach_ok) next_flags[B_ATTACH] = 1'b1;
    if (k_cnt == 13'(SETTLE_CYC - 1)) next_flags[B_RESUME] = 1'b1;
    if (idle_cnt == 18'(IDLE_CYCLES - 1)) next_flags[B_IDLE] = 1'b1;
    // A pop lets the clear through; the flag returns next cycle if entries remain
    if (!tok.empty && !tok.pop) next_flags[B_TOKEN] = 1'b1;
    if (ctrl[C_HOST_OPERATION_ENABLE] ? sof_tick : i_sof_rx) next_flags[B_SOF] = 1'b1;
    if (|(i_err_evt & err_en)) next_flags[B_ERR] = 1'b1;
    if (!ctrl[C_HOST_OPERATION_ENABLE] && i_bus_reset_evt) next_flags[B_RST] = 1'b1;
    if (ctrl[C_HOST_OPERATION_ENABLE] && i_detach_evt) next_flags[B_RST] = 1'b1;
    // Read mux for the next data phase
    if (i_hready && i_hsel && i_htrans[1] && !i_hwrite) begin
      if (i_haddr == OFS_FLAGS) begin
        next_rdata = {24'h000000, next_flags};
      end else if (i_haddr == OFS_FLAG_EN) begin
        next_rdata = {24'h000000, next_flag_en};
      end else if (i_haddr == OFS_ERR_EN) begin
        next_rdata = {24'h000000, next_err_en};
      end else if (i_haddr == OFS_CTRL) begin
        next_rdata = {24'h000000, next_ctrl};
      end else if (i_haddr == OFS_STAT) begin
        next_rdata = {22'h000000, i_token_busy, tok.empty, tok.rdata};
      end
    end
    // Line timers: attach settle (J), K state, idle (J) state
    next_settle_cnt = 13'(sat_inc({5'h00, settle_cnt}, line == LS_J, 18'h01fff));
    next_k_cnt      = 13'(sat_inc({5'h00, k_cnt}, line == LS_K, 18'h01fff));
    next_idle_cnt   = sat_inc(idle_cnt, line == LS_J, 18'h3ffff);
    next_host_q     = ctrl[C_HOST_OPERATION_ENABLE];
    next_frame_cnt  = (sof_tick || !ctrl[C_FRAME_START_ENABLE]) ? 18'h00000 : frame_cnt + 18'h00001;
    if (host_q != ctrl[C_HOST_OPERATION_ENABLE]) begin
      next_frame_cnt = 18'h00000;
    end
  end

  // Token FIFO: push from engine, pop on software clear
  assign tok.push  = i_token_done;
  assign tok.wdata = i_token_stat;
  assign tok.pop   = wr_ones[B_TOKEN] && flags[B_TOKEN];
  assign tok.flush = i_srst;

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      flags      <= FLAGS_RST;
      flag_en    <= 8'h00;
      err_en     <= 8'h00;
      ctrl       <= CTRL_RST;
      rdata      <= 32'h00000000;
      settle_cnt <= 13'h0000;
      k_cnt      <= 13'h0000;
      idle_cnt   <= 18'h00000;
      frame_cnt  <= 18'h00000;
      host_q     <= 1'b0;
    end else begin
      flags      <= next_flags;
      flag_en    <= next_flag_en;
      err_en     <= next_err_en;
      ctrl       <= next_ctrl;
      rdata      <= next_rdata;
      settle_cnt <= next_settle_cnt;
      k_cnt      <= next_k_cnt;
      idle_cnt   <= next_idle_cnt;
      frame_cnt  <= next_frame_cnt;
      host_q     <= next_host_q;
    end
  end

  // Resume signalling; host appends a low-speed EOP on release
  always_comb begin
    next_rs      = rs;
    next_eop_cnt = 8'h00;
    case (rs)
      RS_OFF: if (ctrl[C_RESUME]) next_rs = RS_K;
      RS_K: begin
        if (!ctrl[C_RESUME]) next_rs = ctrl[C_HOST_OPERATION_ENABLE] ? RS_EOP : RS_OFF;
      end
      RS_EOP: begin
        next_eop_cnt = eop_cnt + 8'h01;
        if (eop_cnt == 8'(EOP_CYC - 1)) next_rs = RS_OFF;
      end
      default: next_rs = RS_OFF;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      rs      <= RS_OFF;
      eop_cnt <= 8'h00;
    end else begin
      rs      <= next_rs;
      eop_cnt <= next_eop_cnt;
    end
  end

  // Control outputs, registered
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_module_on      <= 1'b0;
      o_pingpong_even  <= 1'b0;
      o_host_logic_rst <= 1'b0;
      o_sof_send       <= 1'b0;
      o_resume_drive   <= 1'b0;
      o_ls_eop_drive   <= 1'b0;
      o_irq            <= 1'b0;
    end else begin
      o_module_on      <= ctrl[C_ENABLE];
      o_pingpong_even  <= ctrl[C_PPRST];
      o_host_logic_rst <= host_q != ctrl[C_HOST_OPERATION_ENABLE];
      o_sof_send       <= sof_tick;
      o_resume_drive   <= rs == RS_K;
      o_ls_eop_drive   <= rs == RS_EOP;
      o_irq            <= |(flags & flag_en);
    end
  end
endmodule
`default_nettype wire

// ===== dv/uef_line_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far-side line driver: holds the commanded bus state on D+ and D-
module uef_line_model (
  input  wire logic               i_ref_clk,
  input  wire uef_pkg::uef_line_t i_state,
  output logic                    o_dp,
  output logic                    o_dm
);
  import uef_pkg::*;
  // Registered so a state change lands cleanly after an edge
  always_ff @(posedge i_ref_clk) begin
    {o_dm, o_dp} <= i_state;
  end
endmodule
`default_nettype wire

// ===== dv/uef_props.sv
`timescale 1ns/1ps
`default_nettype none
module uef_props (
  input wire logic        i_ref_clk,
  input wire logic        i_srst,
  input wire logic        i_hsel,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic        i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic        o_hreadyout,
  input wire logic        o_hresp,
  input wire logic        o_module_on,
  input wire logic        o_host_logic_rst,
  input wire logic        o_sof_send,
  input wire logic        o_ls_eop_drive,
  input wire logic        o_irq
);
  logic rd_q, wr_q, next_rd_q, next_wr_q;
  // Data phase trackers
  always_comb begin
    next_rd_q = i_hsel & i_hready & i_htrans[1] & ~i_hwrite;
    next_wr_q = i_hsel & i_hready & i_htrans[1] & i_hwrite;
  end
  always_ff @(posedge i_ref_clk) begin
    rd_q <= i_srst ? 1'b0 : next_rd_q;
    wr_q <= i_srst ? 1'b0 : next_wr_q;
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  chk_resp_okay: assert property (o_hresp == 1'b0) else $error("bad response");
  chk_ready_high: assert property (o_hreadyout == 1'b1) else $error("ready low");
  chk_rdata_idle: assert property (!rd_q |-> o_hrdata == 32'h0) else $error("stray data");
  chk_rdata_upper: assert property (o_hrdata[31:10] == 22'h0) else $error("upper bits set");
  chk_sof_gap: assert property (o_sof_send |=> !o_sof_send [*8])
    else $error("frame ticks too close");
  chk_host_rst_pulse: assert property (o_host_logic_rst |=> !o_host_logic_rst)
    else $error("host reset not a pulse");
  chk_reset_outs: assert property ($fell(i_srst) |-> !o_irq && !o_module_on && !o_sof_send)
    else $error("outputs not cleared");
  // Enable may only move after a write or a reset
  chk_enable_cause: assert property ($changed(o_module_on) |->
    $past(wr_q | i_srst) || $past(wr_q | i_srst, 2)) else $error("enable moved");
  cov_sof: cover property (o_sof_send);
  cov_hrst: cover property (o_host_logic_rst);
  cov_irq: cover property (o_irq);
  cov_eop: cover property (o_ls_eop_drive);
endmodule
bind uef_top uef_props u_props (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_hsel(i_hsel),
  .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready), .o_hrdata(o_hrdata),
  .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_module_on(o_module_on),
  .o_host_logic_rst(o_host_logic_rst), .o_sof_send(o_sof_send),
  .o_ls_eop_drive(o_ls_eop_drive), .o_irq(o_irq));
`default_nettype wire

// ===== dv/uef_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module uef_top_tb;
  import uef_pkg::*;
  localparam int FRAME = 40;
  logic clk, srst, hsel, hwrite, tbusy, dp, dm, hrdy, hresp, rdy_n;
  logic mon, ppe, hrst, sof, resd, eop, irq;
  logic [1:0] htrans;
  logic [7:0] haddr, tstat, errv;
  logic [31:0] hwdata, hrdata, rd_n;
  logic [5:0] ev;
  logic [4:0] o_n;
  uef_line_t line;
  int bad_count = 0, n_tests = 0, hrst_n = 0, eop_n = 0;
  uef_top #(.IDLE_CYCLES(50), .FRAME_CYCLES(FRAME), .TOK_DEPTH(4)) dut (
    .i_ref_clk(clk), .i_srst(srst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'b010), .i_hwdata(hwdata), .i_hready(hrdy),
    .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp), .i_dp(dp), .i_dm(dm),
    .i_stall_evt(ev[0]), .i_token_done(ev[1]), .i_token_stat(tstat), .i_sof_rx(ev[2]),
    .i_err_evt(errv), .i_attach_evt(ev[3]), .i_detach_evt(ev[4]), .i_bus_reset_evt(ev[5]),
    .i_token_busy(tbusy), .o_module_on(mon), .o_pingpong_even(ppe),
    .o_host_logic_rst(hrst), .o_sof_send(sof), .o_resume_drive(resd),
    .o_ls_eop_drive(eop), .o_irq(irq));
  uef_line_model far (.i_ref_clk(clk), .i_state(line), .o_dp(dp), .o_dm(dm));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Sample at the falling edge so reads never race the rising edge
  always @(negedge clk) begin
    rd_n = hrdata;
    rdy_n = hrdy;
    o_n = {eop, resd, ppe, mon, irq};
  end
  always @(posedge clk) begin
    hrst_n <= hrst_n + int'(hrst === 1'b1);
    eop_n <= eop_n + int'(eop === 1'b1);
  end
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Bounded wait for ready; ready is never assumed
  task automatic edge_rdy;
    int k;
    k = 0;
    @(posedge clk);
    while (rdy_n !== 1'b1) begin
      k++;
      if (k > 16) begin
        bad_count++;
        stop_test;
      end
      @(posedge clk);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    edge_rdy;
    htrans <= 2'b00;
    hwdata <= d;
    edge_rdy;
    r = rd_n;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(r & m, e);
  endtask
  task automatic pulse(input int i);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev <= 6'h00;
    cyc(2);
  endtask
  task automatic t_regs;
    rdchk(OFS_FLAGS, '1, 32'(FLAGS_RST));
    rdchk(OFS_CTRL, '1, 32'(CTRL_RST));
    wr(8'h40, 32'hff);
    rdchk(8'h40, '1, 32'h0);
  endtask
  task automatic t_flags;
    int eb[3];
    int fb[3];
    logic [31:0] m;
    eb = '{0, 2, 5};
    fb = '{B_STALL, B_SOF, B_RST};
    wr(OFS_CTRL, 32'(1) << C_ENABLE);
    for (int j = 0; j < 3; j++) begin
      m = 32'(1) << fb[j];
      pulse(eb[j]);
      rdchk(OFS_FLAGS, m, m);
      wr(OFS_FLAGS, ~m);
      rdchk(OFS_FLAGS, m, m);
      wr(OFS_FLAGS, m);
      rdchk(OFS_FLAGS, m, 32'h0);
    end
    // Disabled error sources must stay silent
    m = 32'(1) << B_ERR;
    for (int k = 0; k < 2; k++) begin
      wr(OFS_ERR_EN, 32'(k));
      errv <= 8'h01;
      @(posedge clk);
      errv <= 8'h00;
      cyc(2);
      rdchk(OFS_FLAGS, m, (k == 1) ? m : 32'h0);
    end
  endtask
  task automatic t_irq;
    wr(OFS_FLAG_EN, 32'h0);
    pulse(0);
    chk(32'(o_n[0]), 32'h0);
    wr(OFS_FLAG_EN, 32'(1) << B_STALL);
    cyc(2);
    chk(32'(o_n[0]), 32'h1);
    wr(OFS_FLAGS, 32'hff);
    cyc(2);
    chk(32'(o_n[0]), 32'h0);
    wr(OFS_FLAG_EN, 32'h0);
  endtask
  task automatic t_token;
    tbusy <= 1'b1;
    tstat <= 8'ha5;
    ev[1] <= 1'b1;
    @(posedge clk);
    tstat <= 8'h3c;
    @(posedge clk);
    ev <= 6'h00;
    cyc(2);
    rdchk(OFS_STAT, '1, 32'h2a5);
    wr(OFS_FLAGS, 32'h8);
    cyc(2);
    rdchk(OFS_FLAGS, 32'h8, 32'h8);
    rdchk(OFS_STAT, '1, 32'h23c);
    wr(OFS_FLAGS, 32'h8);
    cyc(2);
    rdchk(OFS_FLAGS, 32'h8, 32'h0);
    rdchk(OFS_STAT, 32'h100, 32'h100);
    tbusy <= 1'b0;
  endtask
  task automatic t_line;
    logic [31:0] mr, mi;
    mr = 32'(1) << B_RESUME;
    mi = 32'(1) << B_IDLE;
    line <= LS_K;
    wr(OFS_FLAGS, 32'hff);
    cyc(20);
    rdchk(OFS_FLAGS, mr, 32'h0);
    cyc(90);
    rdchk(OFS_FLAGS, mr, mr);
    line <= LS_J;
    wr(OFS_FLAGS, 32'hff);
    cyc(60);
    rdchk(OFS_FLAGS, mi, mi);
  endtask
  task automatic t_host;
    int h, n;
    logic [31:0] ma;
    ma = 32'(1) << B_ATTACH;
    h = hrst_n;
    wr(OFS_CTRL, 32'(1) << C_HOST_OPERATION_ENABLE);
    cyc(3);
    chk(32'(hrst_n - h), 32'h1);
    cyc(110);
    pulse(3);
    rdchk(OFS_FLAGS, ma, ma);
    line <= LS_SE0;
    wr(OFS_FLAGS, 32'hff);
    cyc(4);
    pulse(3);
    rdchk(OFS_FLAGS, ma, 32'h0);
    line <= LS_J;
    pulse(4);
    rdchk(OFS_FLAGS, 32'h1, 32'h1);
    wr(OFS_FLAGS, 32'hff);
    pulse(5);
    rdchk(OFS_FLAGS, 32'h1, 32'h0);
    wr(OFS_CTRL, (32'(1) << C_HOST_OPERATION_ENABLE) | (32'(1) << C_FRAME_START_ENABLE));
    for (int k = 0; k < 3; k++) begin
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (sof !== 1'b1 && n < 100);
      if (k == 1) chk(32'(n), 32'(FRAME));
      if (k == 1) @(posedge clk);
      if (k == 1) wr(OFS_CTRL, 32'(1) << C_HOST_OPERATION_ENABLE);
    end
    chk(32'(n), 32'd100);
    @(posedge clk);
    wr(OFS_CTRL, (32'(1) << C_HOST_OPERATION_ENABLE) | (32'(1) << C_RESUME));
    cyc(3);
    chk(32'(o_n[3]), 32'h1);
    h = eop_n;
    wr(OFS_CTRL, 32'(1) << C_HOST_OPERATION_ENABLE);
    cyc(4);
    chk(32'(eop_n > h), 32'h1);
    cyc(60);
  endtask
  task automatic t_ctrl;
    wr(OFS_CTRL, (32'(1) << C_ENABLE) | (32'(1) << C_PPRST));
    cyc(3);
    chk(32'(o_n[1]), 32'h1);
    chk(32'(o_n[2]), 32'h1);
    wr(OFS_CTRL, 32'h0);
    cyc(3);
    chk(32'(o_n[1]), 32'h0);
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    stop_test;
  end
  initial begin
    srst = 1'b1; hsel = 1'b1; hwrite = 1'b0; htrans = 2'b00; haddr = 8'h00;
    hwdata = 32'h0; ev = 6'h00; errv = 8'h00; tstat = 8'h00; tbusy = 1'b0; line = LS_J;
    cyc(10);
    srst <= 1'b0;
    @(posedge clk);
    t_regs;
    t_flags;
    t_irq;
    t_token;
    t_line;
    t_host;
    t_ctrl;
    stop_test;
  end
endmodule
`default_nettype wire
